/* File: cscs_host.sv */
// Remote host model: APB master issuing screen commands
`timescale 1ns/1ps
module cscs_host (
	input wire logic mclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	logic [31:0] rdata;
	logic rerr;
	initial
	begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// Request held until ready; released data inverted so stale values never match
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		@(posedge mclk);
		while (pready !== 1'h1)
		begin
			@(posedge mclk);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		pwdata <= ~d;
	endtask : xfer
endmodule : cscs_host

/* File: cscs_pkg.sv */
// Constants, register map and field layout for the custom screen cell store
package cscs_pkg;

	// ****************************************
	// Screen geometry and field ranges
	// ****************************************
	localparam int ROWS = 15;
	localparam int COLS = 4;
	localparam int CELLS = 57;
	localparam int TEXT_MAX = 60;
	localparam int DEF_TEXT_MAX = 5;
	localparam logic [2:0] SIZE_MAX = 3'h4;
	localparam logic [1:0] JUST_MAX = 2'h2;
	localparam logic [2:0] SZ_12 = 3'h0;
	localparam logic [2:0] SZ_16 = 3'h1;
	localparam logic [2:0] SZ_22 = 3'h2;
	localparam logic [2:0] SZ_28 = 3'h3;
	localparam logic [2:0] SZ_36 = 3'h4;
	localparam logic [1:0] JUST_LEFT = 2'h0;
	localparam logic [1:0] JUST_CENTRE = 2'h1;
	localparam logic [1:0] JUST_RIGHT = 2'h2;

	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_ATTR = 8'h08;
	localparam logic [7:0] REG_COLOUR = 8'h0C;
	localparam logic [7:0] REG_TLEN = 8'h10;
	localparam logic [7:0] REG_TPTR = 8'h14;
	localparam logic [7:0] REG_TDATA = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_QATTR = 8'h20;
	localparam logic [7:0] REG_QCOLOUR = 8'h24;
	localparam logic [7:0] REG_QTLEN = 8'h28;
	localparam logic [7:0] REG_QADDR = 8'h2C;

	// ****************************************
	// Command opcodes, CMD[2:0]
	// ****************************************
	localparam logic [2:0] OP_BLANK = 3'h1;
	localparam logic [2:0] OP_SET = 3'h2;
	localparam logic [2:0] OP_QUERY = 3'h3;
	localparam logic [2:0] OP_COMMIT = 3'h4;

	// ****************************************
	// Register field positions
	// ****************************************
	localparam int ADDR_ROW_LSB = 0;
	localparam int ADDR_COL_LSB = 8;
	localparam int ATTR_SIZE_LSB = 0;
	localparam int ATTR_JUST_LSB = 4;
	localparam int ATTR_UNITS_BIT = 8;
	localparam int ATTR_DEF_LSB = 16;
	localparam int COL_R_LSB = 0;
	localparam int COL_G_LSB = 8;
	localparam int COL_B_LSB = 16;
	localparam int ST_ERR_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_LOCK_BIT = 2;
	localparam int ST_QVALID_BIT = 3;

	// ****************************************
	// Stored cell word: size,just,units,def,r,g,b,len
	// ****************************************
	localparam int CW_LEN_LSB = 0;
	localparam int CW_B_LSB = 6;
	localparam int CW_G_LSB = 14;
	localparam int CW_R_LSB = 22;
	localparam int CW_DEF_LSB = 30;
	localparam int CW_UNITS_BIT = 38;
	localparam int CW_JUST_LSB = 39;
	localparam int CW_SIZE_LSB = 41;
	localparam int CW_BITS = 44;
	localparam logic [43:0] CELL_EMPTY = 44'h000_0000_0000;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [31:0] RST_REG = 32'h0000_0000;
	localparam longint CLK_HZ = 20000000;
	localparam longint LOCK_MS = 300;
	localparam int LOCK_CYCLES = int'(LOCK_MS * CLK_HZ / 1000);

	// Flat cell number: row 0 is cell 0, then four cells a row
	function automatic logic [5:0] cscs_cell_index(input logic [3:0] row, input logic [1:0] col);
		logic [7:0] idx;
		idx = 8'h00;
		if (row != 4'h0)
		begin
			idx = 8'({row - 4'h1, 2'b00}) + 8'h01 + 8'(col);
		end
		return idx[5:0];
	endfunction : cscs_cell_index

endpackage : cscs_pkg

/* File: cscs_region.sv */
// Cell position check and merged region span for one cell
`timescale 1ns/1ps
module cscs_region (
	input wire logic [3:0] row,
	input wire logic [1:0] col,
	input wire logic [2:0] size,
	output logic [5:0] index,
	output logic legal,
	output logic fits,
	output logic [1:0] span_w,
	output logic [1:0] span_h
);
	logic merge;

	always_comb
	begin
		index = cscs_pkg::cscs_cell_index(row, col);
		legal = (row < 4'(cscs_pkg::ROWS)) && ((row != 4'h0) || (col == 2'h0)); // [RL5] [RL10]
		merge = (row != 4'h0) && (size != cscs_pkg::SZ_12) && (size != cscs_pkg::SZ_16); // [RL6]
		span_w = (merge && (size >= cscs_pkg::SZ_22)) ? 2'h2 : 2'h1; // [RL7]
		span_h = (merge && (size >= cscs_pkg::SZ_28)) ? 2'h2 : 2'h1; // [RL8]
		fits = ((span_w == 2'h1) || (col < 2'(cscs_pkg::COLS - 1)))
			&& ((span_h == 2'h1) || (row < 4'(cscs_pkg::ROWS - 1)));
	end

endmodule : cscs_region

/* File: cscs_store.sv */
// Custom screen cell store: APB command registers, staging and active screens
//
// Functional notes
// [RL1] Edits staged; active screen changes only on commit
// [RL2] Host should blank before building new screen
// [RL3] After commit, 300ms lockout; commands raise error
// [RL4] Host ends each set-cell with terminator
// [RL5] 57 cells: row 0 single, rows 1-14 four
// [RL6] Merging only outside row 0, sizes above 16pix
// [RL7] 22pix also covers right neighbour
// [RL8] 28/36pix cover two-by-two block
// [RL9] Blank command empties every staged cell
// [RL10] Set-cell addresses row 0-14, column 0-3
// [RL11] Size codes 0-4 mean 12,16,22,28,36 pix
// [RL12] Justification codes 0-2: left, centre, right
// [RL13] Each cell stores red, green, blue colour
// [RL14] Cell stores optional selector and units flag
// [RL15] Show 5 chars with selector, else 60
// [RL16] Blank selector and text: only row/column used
// [RL17] Query returns full definition of a cell
// [RL18] Commit copies staged screen to active screen
// [RL19] Out-of-range fields raise error, cells untouched
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cscs_store #(
	parameter int LOCK_CYCLES = cscs_pkg::LOCK_CYCLES
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [3:0] DISP_ROW,
	input wire logic [1:0] DISP_COL,
	input wire logic [5:0] DISP_CHAR,
	output logic [2:0] DISP_SIZE,
	output logic [1:0] DISP_JUST,
	output logic [23:0] DISP_RGB,
	output logic [7:0] DISP_DEF,
	output logic DISP_UNITS,
	output logic [5:0] DISP_LEN,
	output logic [7:0] DISP_CHAR_DATA,
	output logic [1:0] DISP_SPAN_W,
	output logic [1:0] DISP_SPAN_H
);
	localparam int LW = $clog2(LOCK_CYCLES + 1);
	localparam int CB = cscs_pkg::CW_BITS;

	typedef enum logic [4:0] {
		CSCS_IDLE = 5'b00001,
		CSCS_BLANK = 5'b00010,
		CSCS_SET = 5'b00100,
		CSCS_COMMIT = 5'b01000,
		CSCS_LOCK = 5'b10000
	} cscs_state_t;

	typedef struct packed {
		cscs_state_t state;
		logic [LW-1:0] lock_cnt;
		logic [11:0] walk;
		logic [5:0] tgt;
		logic [CB-1:0] new_word;
		logic [3:0] row;
		logic [1:0] col;
		logic [2:0] size;
		logic [1:0] just;
		logic units;
		logic [7:0] def;
		logic [23:0] rgb;
		logic [5:0] tlen;
		logic [5:0] tptr;
		logic err;
		logic q_valid;
		logic [5:0] q_cell;
		logic [3:0] q_row;
		logic [1:0] q_col;
		logic [CB-1:0] q_word;
		logic ack;
		logic [31:0] prdata;
		logic slverr;
		logic [CB-1:0] disp_word;
		logic [7:0] disp_char;
		logic [1:0] disp_w;
		logic [1:0] disp_h;
	} cscs_regs_t;

	cscs_regs_t s;
	cscs_regs_t next_s;

	// ****************************************
	// Memories
	// ****************************************
	// Text kept at {cell, char}: 64 slots a cell keeps addressing a plain concatenation
	logic [CB-1:0] stage_attr [0:63];
	logic [CB-1:0] active_attr [0:63];
	logic [7:0] stage_text [0:4095];
	logic [7:0] active_text [0:4095];
	logic [7:0] cmd_text [0:63];

	logic sa_we;
	logic [5:0] sa_idx;
	logic [CB-1:0] sa_data;
	logic aa_we;
	logic st_we;
	logic [11:0] st_addr;
	logic at_we;
	logic ct_we;

	logic [5:0] c_idx;
	logic c_legal;
	logic c_fits;
	logic [5:0] d_idx;
	logic [CB-1:0] d_word;
	logic d_legal;
	logic [1:0] d_w;
	logic [1:0] d_h;

	cscs_region u_cmd_region (
		.row(s.row),
		.col(s.col),
		.size(s.size),
		.index(c_idx),
		.legal(c_legal),
		.fits(c_fits),
		.span_w(),
		.span_h()
	);

	always_comb
	begin
		d_word = active_attr[cscs_pkg::cscs_cell_index(DISP_ROW, DISP_COL)];
	end

	cscs_region u_disp_region (
		.row(DISP_ROW),
		.col(DISP_COL),
		.size(d_word[cscs_pkg::CW_SIZE_LSB +: 3]),
		.index(d_idx),
		.legal(d_legal),
		.fits(),
		.span_w(d_w),
		.span_h(d_h)
	);

	// ****************************************
	// Next state
	// ****************************************
	logic acc;
	logic done;
	logic wr;
	logic rd_done;
	logic mapped;
	logic err_set;
	logic set_ok;
	logic [2:0] op;
	logic [31:0] rd;
	logic [5:0] dlen;

	always_comb
	begin
		next_s = s;
		sa_we = 1'b0;
		sa_idx = s.walk[5:0];
		sa_data = cscs_pkg::CELL_EMPTY;
		aa_we = 1'b0;
		st_we = 1'b0;
		st_addr = {s.tgt, s.walk[5:0]};
		at_we = 1'b0;
		ct_we = 1'b0;
		err_set = 1'b0;
		op = PWDATA[2:0];
		mapped = (PADDR[1:0] == 2'b00) && (PADDR <= cscs_pkg::REG_QADDR);
		acc = PSEL && PENABLE && !s.ack;
		done = PSEL && PENABLE && s.ack;
		wr = done && PWRITE && mapped;
		rd_done = done && !PWRITE && mapped;
		set_ok = c_legal && c_fits && (s.size <= cscs_pkg::SIZE_MAX)
			&& (s.just <= cscs_pkg::JUST_MAX) && (s.tlen <= 6'(cscs_pkg::TEXT_MAX)); // [RL19]
		case (PADDR)
			cscs_pkg::REG_ADDR: rd = 32'({s.col, 4'h0, s.row} << cscs_pkg::ADDR_ROW_LSB);
			cscs_pkg::REG_ATTR: rd = {8'h00, s.def, 7'h00, s.units, 2'h0, s.just, 1'b0, s.size};
			cscs_pkg::REG_COLOUR: rd = {8'h00, s.rgb};
			cscs_pkg::REG_TLEN: rd = {26'h000_0000, s.tlen};
			cscs_pkg::REG_TPTR: rd = {26'h000_0000, s.tptr};
			cscs_pkg::REG_TDATA: rd = {24'h00_0000, stage_text[{s.q_cell, s.tptr}]};
			cscs_pkg::REG_STATUS: rd = {28'h000_0000, s.q_valid, (s.state == CSCS_LOCK),
				(s.state != CSCS_IDLE) && (s.state != CSCS_LOCK), s.err};
			cscs_pkg::REG_QATTR: rd = {8'h00, s.q_word[cscs_pkg::CW_DEF_LSB +: 8], 7'h00,
				s.q_word[cscs_pkg::CW_UNITS_BIT], 2'h0, s.q_word[cscs_pkg::CW_JUST_LSB +: 2],
				1'b0, s.q_word[cscs_pkg::CW_SIZE_LSB +: 3]}; // [RL17]
			cscs_pkg::REG_QCOLOUR: rd = {8'h00, s.q_word[cscs_pkg::CW_B_LSB +: 24]}; // [RL17]
			cscs_pkg::REG_QTLEN: rd = {26'h000_0000, s.q_word[cscs_pkg::CW_LEN_LSB +: 6]};
			cscs_pkg::REG_QADDR: rd = {22'h00_0000, s.q_col, 4'h0, s.q_row};
			default: rd = cscs_pkg::RST_REG;
		endcase

		// APB: one wait state, write and pointer step on the completing edge
		next_s.ack = acc;
		next_s.slverr = acc && !mapped;
		if (acc)
		begin
			next_s.prdata = rd;
		end
		if (rd_done && (PADDR == cscs_pkg::REG_TDATA))
		begin
			next_s.tptr = s.tptr + 6'h01;
		end
		if (wr)
		begin
			case (PADDR)
				cscs_pkg::REG_ADDR:
				begin
					next_s.row = PWDATA[cscs_pkg::ADDR_ROW_LSB +: 4];
					next_s.col = PWDATA[cscs_pkg::ADDR_COL_LSB +: 2];
				end
				cscs_pkg::REG_ATTR:
				begin
					next_s.size = PWDATA[cscs_pkg::ATTR_SIZE_LSB +: 3]; // [RL11]
					next_s.just = PWDATA[cscs_pkg::ATTR_JUST_LSB +: 2]; // [RL12]
					next_s.units = PWDATA[cscs_pkg::ATTR_UNITS_BIT]; // [RL14]
					next_s.def = PWDATA[cscs_pkg::ATTR_DEF_LSB +: 8]; // [RL14]
				end
				cscs_pkg::REG_COLOUR: next_s.rgb = {PWDATA[cscs_pkg::COL_R_LSB +: 8],
					PWDATA[cscs_pkg::COL_G_LSB +: 8], PWDATA[cscs_pkg::COL_B_LSB +: 8]}; // [RL13]
				cscs_pkg::REG_TLEN: next_s.tlen = PWDATA[5:0];
				cscs_pkg::REG_TPTR: next_s.tptr = PWDATA[5:0];
				cscs_pkg::REG_TDATA:
				begin
					ct_we = 1'b1;
					next_s.tptr = s.tptr + 6'h01;
				end
				cscs_pkg::REG_STATUS:
				begin
					if (PWDATA[cscs_pkg::ST_ERR_BIT])
					begin
						next_s.err = 1'b0;
					end
				end
				cscs_pkg::REG_CMD:
				begin
					if (s.state != CSCS_IDLE)
					begin
						err_set = 1'b1; // [RL3]
					end
					else
					begin
						case (op)
							cscs_pkg::OP_BLANK:
							begin
								next_s.state = CSCS_BLANK;
								next_s.walk = 12'h000;
							end
							cscs_pkg::OP_SET:
							begin
								if (set_ok)
								begin
									next_s.state = CSCS_SET;
									next_s.walk = 12'h000;
									next_s.tgt = c_idx;
									// Selector and text both blank: the cell keeps row/column only
									if ((s.def == 8'h00) && (s.tlen == 6'h00)) // [RL16]
									begin
										next_s.new_word = cscs_pkg::CELL_EMPTY;
									end
									else
									begin
										next_s.new_word = {s.size, s.just, s.units, s.def, s.rgb, s.tlen};
									end
								end
								else
								begin
									err_set = 1'b1; // [RL19]
								end
							end
							cscs_pkg::OP_QUERY:
							begin
								if (c_legal)
								begin
									next_s.q_word = stage_attr[c_idx]; // [RL17]
									next_s.q_cell = c_idx;
									next_s.q_row = s.row;
									next_s.q_col = s.col;
									next_s.q_valid = 1'b1;
									next_s.tptr = 6'h00;
								end
								else
								begin
									err_set = 1'b1; // [RL19]
								end
							end
							cscs_pkg::OP_COMMIT:
							begin
								next_s.state = CSCS_COMMIT;
								next_s.walk = 12'h000;
							end
							default: err_set = 1'b1;
						endcase
					end
				end
				default: next_s.err = s.err;
			endcase
		end

		// ****************************************
		// Sequencer
		// ****************************************
		case (s.state)
			CSCS_BLANK:
			begin
				sa_we = 1'b1; // [RL9]
				next_s.q_valid = 1'b0;
				next_s.walk = s.walk + 12'h001;
				if (s.walk == 12'(cscs_pkg::CELLS - 1))
				begin
					next_s.state = CSCS_IDLE;
				end
			end
			CSCS_SET:
			begin
				st_we = 1'b1; // [RL1]
				next_s.walk = s.walk + 12'h001;
				if (s.walk == 12'h03F)
				begin
					sa_we = 1'b1;
					sa_idx = s.tgt;
					sa_data = s.new_word;
					next_s.state = CSCS_IDLE;
				end
			end
			CSCS_COMMIT:
			begin
				at_we = 1'b1; // [RL18]
				aa_we = (s.walk[5:0] == 6'h00);
				next_s.walk = s.walk + 12'h001;
				if (s.walk == 12'hFFF)
				begin
					next_s.state = CSCS_LOCK;
					next_s.lock_cnt = '0;
				end
			end
			CSCS_LOCK:
			begin
				next_s.lock_cnt = s.lock_cnt + LW'(1);
				if (s.lock_cnt >= LW'(LOCK_CYCLES - 1)) // [RL3]
				begin
					next_s.state = CSCS_IDLE;
				end
			end
			CSCS_IDLE: next_s.lock_cnt = '0;
			default: next_s.state = CSCS_IDLE;
		endcase
		if (err_set)
		begin
			next_s.err = 1'b1;
		end

		// ****************************************
		// Display read port from the active screen
		// ****************************************
		next_s.disp_word = d_legal ? d_word : cscs_pkg::CELL_EMPTY;
		next_s.disp_char = active_text[{d_idx, DISP_CHAR}];
		next_s.disp_w = d_w;
		next_s.disp_h = d_h;
	end

	// ****************************************
	// State and memory registers
	// ****************************************
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			s <= '{state: CSCS_IDLE, default: '0};
		end
		else
		begin
			s <= next_s;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (sa_we)
		begin
			stage_attr[sa_idx] <= sa_data;
		end
		if (aa_we)
		begin
			active_attr[s.walk[11:6]] <= stage_attr[s.walk[11:6]];
		end
		if (st_we)
		begin
			stage_text[st_addr] <= cmd_text[s.walk[5:0]];
		end
		if (at_we)
		begin
			active_text[s.walk] <= stage_text[s.walk];
		end
		if (ct_we)
		begin
			cmd_text[s.tptr] <= PWDATA[7:0];
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb
	begin
		// Text shown is clipped: five characters beside a result, else sixty
		if (s.disp_word[cscs_pkg::CW_DEF_LSB +: 8] != 8'h00) // [RL15]
		begin
			dlen = (s.disp_word[5:0] > 6'(cscs_pkg::DEF_TEXT_MAX)) ? 6'(cscs_pkg::DEF_TEXT_MAX)
				: s.disp_word[5:0];
		end
		else
		begin
			dlen = (s.disp_word[5:0] > 6'(cscs_pkg::TEXT_MAX)) ? 6'(cscs_pkg::TEXT_MAX)
				: s.disp_word[5:0];
		end
	end

	assign PRDATA = s.prdata;
	assign PREADY = s.ack;
	assign PSLVERR = s.slverr;
	assign DISP_SIZE = s.disp_word[cscs_pkg::CW_SIZE_LSB +: 3];
	assign DISP_JUST = s.disp_word[cscs_pkg::CW_JUST_LSB +: 2];
	assign DISP_RGB = s.disp_word[cscs_pkg::CW_B_LSB +: 24];
	assign DISP_DEF = s.disp_word[cscs_pkg::CW_DEF_LSB +: 8];
	assign DISP_UNITS = s.disp_word[cscs_pkg::CW_UNITS_BIT];
	assign DISP_LEN = dlen;
	assign DISP_CHAR_DATA = s.disp_char;
	assign DISP_SPAN_W = s.disp_w;
	assign DISP_SPAN_H = s.disp_h;

endmodule : cscs_store

/* File: cscs_store_properties.sv */
// Port-level assertions for the custom screen cell store
`timescale 1ns/1ps
module cscs_store_properties (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [3:0] DISP_ROW,
	input wire logic [2:0] DISP_SIZE,
	input wire logic [1:0] DISP_JUST,
	input wire logic [7:0] DISP_DEF,
	input wire logic [5:0] DISP_LEN,
	input wire logic [1:0] DISP_SPAN_W,
	input wire logic [1:0] DISP_SPAN_H
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	logic unmapped;
	assign unmapped = (PADDR[1:0] != 2'h0) || (PADDR > 8'h2C);
	// ****************************************
	// APB timing
	// ****************************************
	property p_ready_wait;
		PSEL && PENABLE && !$past(PENABLE) |=> PREADY;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready late");
	property p_ready_pulse;
		PREADY |=> !PREADY;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_no_select;
		!PSEL |=> !PREADY && !PSLVERR;
	endproperty
	a_no_select: assert property (p_no_select) else $error("answer without select");
	property p_unmapped;
		PSEL && PENABLE && !PREADY && unmapped |=> PSLVERR && PREADY && (PWRITE || PRDATA == 0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
	property p_mapped;
		PSEL && PENABLE && !PREADY && !unmapped |=> !PSLVERR;
	endproperty
	a_mapped: assert property (p_mapped) else $error("mapped refused");
	// ****************************************
	// Display region and fields
	// ****************************************
	property p_row0;
		$past(DISP_ROW) == 4'h0 |-> DISP_SPAN_W == 2'h1 && DISP_SPAN_H == 2'h1;
	endproperty
	a_row0: assert property (p_row0) else $error("row 0 merged");
	property p_small;
		DISP_SIZE <= cscs_pkg::SZ_16 && $past(DISP_ROW) <= 4'hE |-> DISP_SPAN_W == 2'h1
			&& DISP_SPAN_H == 2'h1;
	endproperty
	a_small: assert property (p_small) else $error("small text merged");
	property p_wide;
		DISP_SIZE == cscs_pkg::SZ_22 && $past(DISP_ROW) != 4'h0 |-> DISP_SPAN_W == 2'h2
			&& DISP_SPAN_H == 2'h1;
	endproperty
	a_wide: assert property (p_wide) else $error("22pix span wrong");
	property p_block;
		DISP_SIZE >= cscs_pkg::SZ_28 && $past(DISP_ROW) != 4'h0 |-> DISP_SPAN_W == 2'h2
			&& DISP_SPAN_H == 2'h2;
	endproperty
	a_block: assert property (p_block) else $error("block span wrong");
	property p_len;
		$past(DISP_ROW) <= 4'hE |-> DISP_LEN <= ((DISP_DEF != 8'h00) ? 6'h05 : 6'h3C);
	endproperty
	a_len: assert property (p_len) else $error("shown length too long");
	property p_codes;
		$past(DISP_ROW) <= 4'hE |-> DISP_SIZE <= cscs_pkg::SZ_36
			&& DISP_JUST <= cscs_pkg::JUST_RIGHT;
	endproperty
	a_codes: assert property (p_codes) else $error("code out of range");
endmodule : cscs_store_properties
bind cscs_store cscs_store_properties chk_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .DISP_ROW(DISP_ROW), .DISP_SIZE(DISP_SIZE), .DISP_JUST(DISP_JUST),
	.DISP_DEF(DISP_DEF), .DISP_LEN(DISP_LEN), .DISP_SPAN_W(DISP_SPAN_W),
	.DISP_SPAN_H(DISP_SPAN_H));

/* File: cscs_store_tb.sv */
// Self-checking bench for the custom screen cell store
`timescale 1ns/1ps
module cscs_store_tb;
	// Short lockout keeps the run brief
	localparam int LOCK = 50;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DISP_UNITS;
	logic [7:0] PADDR, DISP_DEF, DISP_CHAR_DATA;
	logic [31:0] PWDATA, PRDATA;
	logic [3:0] DISP_ROW;
	logic [1:0] DISP_COL, DISP_JUST, DISP_SPAN_W, DISP_SPAN_H;
	logic [5:0] DISP_CHAR, DISP_LEN;
	logic [2:0] DISP_SIZE;
	logic [23:0] DISP_RGB;
	int n_errors;
	int checked;
	cscs_store #(.LOCK_CYCLES(LOCK)) dut_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .DISP_ROW(DISP_ROW), .DISP_COL(DISP_COL),
		.DISP_CHAR(DISP_CHAR), .DISP_SIZE(DISP_SIZE), .DISP_JUST(DISP_JUST), .DISP_RGB(DISP_RGB),
		.DISP_DEF(DISP_DEF), .DISP_UNITS(DISP_UNITS), .DISP_LEN(DISP_LEN),
		.DISP_CHAR_DATA(DISP_CHAR_DATA), .DISP_SPAN_W(DISP_SPAN_W), .DISP_SPAN_H(DISP_SPAN_H));
	cscs_host host_u (.mclk(MCLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
		.paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
	initial
	begin
		MCLK = 1'h0;
		forever #25 MCLK = ~MCLK;
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	function automatic logic [31:0] attr(logic [2:0] s, logic [1:0] j, logic u, logic [7:0] d);
		return {8'h00, d, 7'h00, u, 2'h0, j, 1'h0, s};
	endfunction : attr
	function automatic logic [23:0] rgb(logic [3:0] r, logic [1:0] c);
		return {4'hA, r, 8'h5C, 6'h00, c};
	endfunction : rgb
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked = checked + 1;
		if (seen !== exp)
		begin
			n_errors = n_errors + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
		begin
			$display("No errors found");
		end
		else
		begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_u.xfer(1'h1, a, d);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		host_u.xfer(1'h0, a, 32'h0000_0000);
		check(host_u.rdata & m, e);
	endtask : rd_chk
	task automatic idle(input logic [31:0] m);
		int i = 0;
		host_u.xfer(1'h0, cscs_pkg::REG_STATUS, 32'h0000_0000);
		while ((host_u.rdata & m) !== 32'h0000_0000 && i < 3000)
		begin
			host_u.xfer(1'h0, cscs_pkg::REG_STATUS, 32'h0000_0000);
			i++;
		end
		if (i >= 3000)
			n_errors = n_errors + 1;
	endtask : idle
	task automatic cmd(input logic [2:0] op);
		wr(cscs_pkg::REG_CMD, 32'(op));
		idle(32'h0000_0006);
	endtask : cmd
	task automatic set_cell(logic [3:0] r, logic [1:0] c, logic [2:0] s, logic [1:0] j, logic u,
		logic [7:0] d, logic [5:0] n);
		logic [23:0] k;
		k = rgb(r, c);
		wr(cscs_pkg::REG_ADDR, {22'h0, c, 4'h0, r});
		wr(cscs_pkg::REG_ATTR, attr(s, j, u, d));
		wr(cscs_pkg::REG_COLOUR, {8'h00, k[7:0], k[15:8], k[23:16]});
		wr(cscs_pkg::REG_TLEN, 32'(n));
		wr(cscs_pkg::REG_TPTR, 32'h0000_0000);
		for (int i = 0; i < n; i++)
		begin
			wr(cscs_pkg::REG_TDATA, 32'(8'h41 + 8'(i)));
		end
		wr(cscs_pkg::REG_CMD, 32'(cscs_pkg::OP_SET));
		idle(32'h0000_0006);
	endtask : set_cell
	task automatic query_chk(logic [3:0] r, logic [1:0] c, logic [2:0] s, logic [1:0] j, logic u,
		logic [7:0] d, logic [5:0] n, logic [23:0] k);
		wr(cscs_pkg::REG_ADDR, {22'h0, c, 4'h0, r});
		wr(cscs_pkg::REG_CMD, 32'(cscs_pkg::OP_QUERY));
		rd_chk(cscs_pkg::REG_QATTR, ALL, attr(s, j, u, d));
		rd_chk(cscs_pkg::REG_QCOLOUR, ALL, {8'h00, k});
		rd_chk(cscs_pkg::REG_QTLEN, ALL, 32'(n));
		rd_chk(cscs_pkg::REG_QADDR, ALL, {22'h0, c, 4'h0, r});
	endtask : query_chk
	task automatic disp(logic [3:0] r, logic [1:0] c, logic [2:0] s, logic [1:0] j, logic u,
		logic [7:0] d, logic [5:0] n, logic [1:0] w, logic [1:0] h, logic [23:0] k);
		@(posedge MCLK);
		DISP_ROW <= r;
		DISP_COL <= c;
		repeat (2) @(posedge MCLK);
		#1;
		check({8'h00, DISP_SIZE, DISP_JUST, DISP_UNITS, DISP_DEF, DISP_LEN, DISP_SPAN_W,
			DISP_SPAN_H}, {8'h00, s, j, u, d, n, w, h});
		check({8'h00, DISP_RGB}, {8'h00, k});
		if (n != 6'h00)
		begin
			check({24'h00_0000, DISP_CHAR_DATA}, 32'h0000_0041);
		end
	endtask : disp
	task automatic bad(logic [3:0] r, logic [1:0] c, logic [2:0] s, logic [1:0] j);
		set_cell(r, c, s, j, 1'h0, 8'h00, 6'h00);
		rd_chk(cscs_pkg::REG_STATUS, 32'h0000_0007, 32'h0000_0001);
		wr(cscs_pkg::REG_STATUS, 32'h0000_0001);
	endtask : bad
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_reset;
		rd_chk(cscs_pkg::REG_STATUS, ALL, 32'h0000_0000);
		rd_chk(8'h30, ALL, 32'h0000_0000);
		check(32'(host_u.rerr), 32'h0000_0001);
		rd_chk(8'h06, ALL, 32'h0000_0000);
		check(32'(host_u.rerr), 32'h0000_0001);
	endtask : s_reset
	task automatic s_lock;
		cmd(cscs_pkg::OP_BLANK);
		wr(cscs_pkg::REG_CMD, 32'(cscs_pkg::OP_COMMIT));
		idle(32'h0000_0002);
		check(host_u.rdata & 32'h0000_0007, 32'h0000_0004);
		wr(cscs_pkg::REG_CMD, 32'(cscs_pkg::OP_BLANK));
		rd_chk(cscs_pkg::REG_STATUS, 32'h0000_0007, 32'h0000_0005);
		idle(32'h0000_0006);
		wr(cscs_pkg::REG_STATUS, 32'h0000_0001);
		rd_chk(cscs_pkg::REG_STATUS, 32'h0000_0007, 32'h0000_0000);
	endtask : s_lock
	task automatic s_stage;
		set_cell(1, 0, cscs_pkg::SZ_28, cscs_pkg::JUST_RIGHT, 1'h1, 8'h07, 6'h07);
		set_cell(0, 0, cscs_pkg::SZ_22, cscs_pkg::JUST_CENTRE, 1'h0, 8'h00, 6'h03);
		set_cell(2, 2, cscs_pkg::SZ_22, cscs_pkg::JUST_LEFT, 1'h0, 8'h00, 6'h3C);
		set_cell(3, 1, cscs_pkg::SZ_36, cscs_pkg::JUST_CENTRE, 1'h0, 8'h03, 6'h02);
		set_cell(5, 0, cscs_pkg::SZ_12, cscs_pkg::JUST_RIGHT, 1'h1, 8'h00, 6'h01);
		set_cell(14, 3, cscs_pkg::SZ_16, cscs_pkg::JUST_LEFT, 1'h0, 8'h00, 6'h04);
		rd_chk(cscs_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0000);
		query_chk(1, 0, cscs_pkg::SZ_28, cscs_pkg::JUST_RIGHT, 1'h1, 8'h07, 6'h07, rgb(1, 0));
		disp(1, 0, 3'h0, 2'h0, 1'h0, 8'h00, 6'h00, 2'h1, 2'h1, 24'h00_0000);
		cmd(cscs_pkg::OP_COMMIT);
		disp(1, 0, 3'h3, 2'h2, 1'h1, 8'h07, 6'h05, 2'h2, 2'h2, rgb(1, 0));
		disp(0, 0, 3'h2, 2'h1, 1'h0, 8'h00, 6'h03, 2'h1, 2'h1, rgb(0, 0));
		disp(2, 2, 3'h2, 2'h0, 1'h0, 8'h00, 6'h3C, 2'h2, 2'h1, rgb(2, 2));
		disp(3, 1, 3'h4, 2'h1, 1'h0, 8'h03, 6'h02, 2'h2, 2'h2, rgb(3, 1));
		disp(5, 0, 3'h0, 2'h2, 1'h1, 8'h00, 6'h01, 2'h1, 2'h1, rgb(5, 0));
		disp(14, 3, 3'h1, 2'h0, 1'h0, 8'h00, 6'h04, 2'h1, 2'h1, rgb(14, 3));
	endtask : s_stage
	task automatic s_reject;
		bad(4'hF, 0, cscs_pkg::SZ_12, cscs_pkg::JUST_LEFT);
		bad(0, 1, cscs_pkg::SZ_12, cscs_pkg::JUST_LEFT);
		bad(1, 0, 3'h5, cscs_pkg::JUST_LEFT);
		bad(1, 0, cscs_pkg::SZ_12, 2'h3);
		bad(4, 3, cscs_pkg::SZ_22, cscs_pkg::JUST_LEFT);
		cmd(3'h7);
		rd_chk(cscs_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(cscs_pkg::REG_STATUS, 32'h0000_0001);
		query_chk(1, 0, cscs_pkg::SZ_28, cscs_pkg::JUST_RIGHT, 1'h1, 8'h07, 6'h07, rgb(1, 0));
		wr(cscs_pkg::REG_ADDR, 32'h0000_0100);
		wr(cscs_pkg::REG_CMD, 32'(cscs_pkg::OP_QUERY));
		rd_chk(cscs_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(cscs_pkg::REG_STATUS, 32'h0000_0001);
	endtask : s_reject
	task automatic s_blank;
		cmd(cscs_pkg::OP_BLANK);
		query_chk(1, 0, 3'h0, 2'h0, 1'h0, 8'h00, 6'h00, 24'h00_0000);
		disp(1, 0, 3'h3, 2'h2, 1'h1, 8'h07, 6'h05, 2'h2, 2'h2, rgb(1, 0));
		set_cell(2, 1, cscs_pkg::SZ_22, cscs_pkg::JUST_RIGHT, 1'h1, 8'h00, 6'h00);
		query_chk(2, 1, 3'h0, 2'h0, 1'h0, 8'h00, 6'h00, 24'h00_0000);
	endtask : s_blank
	initial
	begin
		RST = 1'h1;
		DISP_ROW = 4'hF;
		DISP_COL = 2'h0;
		DISP_CHAR = 6'h00;
		n_errors = 0;
		checked = 0;
		repeat (2) @(posedge MCLK);
		RST <= 1'h0;
		s_reset;
		s_lock;
		s_stage;
		s_reject;
		s_blank;
		report_and_stop;
	end
	initial
	begin
		repeat (60000) @(posedge MCLK);
		n_errors = n_errors + 1;
		report_and_stop;
	end
endmodule : cscs_store_tb
